/* File: hw/week_timer_pkg.sv */
// package: register map, field layout, reset values and shared types of the week alarm timer
package week_timer_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CONTROL      = 8'h00;
  localparam logic [7:0] OFF_WEEK_COUNT   = 8'h04;
  localparam logic [7:0] OFF_WEEK_COMPARE = 8'h08;
  localparam logic [7:0] OFF_DIVIDER      = 8'h0C;
  localparam logic [7:0] OFF_RATE_SELECT  = 8'h10;
  localparam logic [7:0] OFF_SUB_CONTROL  = 8'h14;
  localparam logic [7:0] OFF_SUB_COUNT    = 8'h18;
  localparam logic [7:0] OFF_BATT_OUTPUT  = 8'h1C;

  // widths
  localparam int WEEK_W = 28;
  localparam int DIV_W  = 15;
  localparam int SUB_W  = 9;
  localparam int RATE_W = 4;
  localparam int SRC_W  = 3;
  localparam int BATT_W = 6;

  // control register field positions
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_WAKE_BIT = 6;
  // sub-week control field positions
  localparam int SUBC_SRC_LSB  = 0;
  localparam int SUBC_REPEAT_BIT = 3;

  // values after reset, and the divider wrap value
  localparam logic              RUN_RESET     = 1'b1;
  localparam logic              WAKE_RESET    = 1'b0;
  localparam logic [WEEK_W-1:0] COMPARE_RESET = 28'h0FFFFFF;
  localparam logic [DIV_W-1:0]  DIV_WRAP      = 15'h7FFF;

  // sub-week tick source codes
  localparam logic [SRC_W-1:0] SRC_OFF     = 3'h0;
  localparam logic [SRC_W-1:0] SRC_SUBSEC  = 3'h1;
  localparam logic [SRC_W-1:0] SRC_SECOND  = 3'h2;
  localparam logic [SRC_W-1:0] SRC_WEEK_B3 = 3'h4;
  localparam logic [SRC_W-1:0] SRC_WEEK_B5 = 3'h5;
  localparam logic [SRC_W-1:0] SRC_WEEK_B7 = 3'h6;
  localparam logic [SRC_W-1:0] SRC_WEEK_B9 = 3'h7;

  // interrupt lines to the aggregator, all launched together
  typedef struct packed {
    logic weekAlarm;
    logic subWeekAlarm;
    logic oneSecond;
    logic subSecond;
  } irq_bundle_type;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

endpackage

/* File: hw/sub_week_counter.sv */
// sub-week down counter with one-shot and repeating modes
`timescale 1ns/1ps
module sub_week_counter (
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  input  wire logic                            tick,
  input  wire logic                            load,
  input  wire logic [week_timer_pkg::SUB_W-1:0] loadValue,
  input  wire logic                            repeatMode,
  output logic      [week_timer_pkg::SUB_W-1:0] count,
  output logic                                 zeroEvent
);

  logic [week_timer_pkg::SUB_W-1:0] count_q;
  logic [week_timer_pkg::SUB_W-1:0] start_q;

  // event when a tick takes the count from one to zero
  assign zeroEvent = tick && !load && (count_q == 9'h001);
  assign count     = count_q;

  // start value captured on every software load
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_q <= 9'h000;
    end else if (load) begin
      start_q <= loadValue;
    end
  end

  // load, reload on wrap, or step down by one
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_q <= 9'h000;
    end else if (load) begin
      count_q <= loadValue;
    end else if (zeroEvent && repeatMode) begin
      count_q <= start_q;
    end else if (tick && (count_q != 9'h000)) begin
      count_q <= count_q - 9'h001;
    end
  end

  stepDown_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tick && !load && count_q > 9'h001) |=> (count_q == $past(count_q) - 9'h001))
    else $error("sub-week counter did not step down by one");

  reload_a: assert property (@(posedge clk) disable iff (!rst_b)
    (zeroEvent && repeatMode) |=> (count_q == $past(start_q)))
    else $error("repeating counter did not reload");

  oneShot_a: assert property (@(posedge clk) disable iff (!rst_b)
    (zeroEvent && !repeatMode) |=> (count_q == 9'h000) [*2])
    else $error("one-shot counter left zero");

endmodule

/* File: hw/battery_week_alarm_timer.sv */
// week alarm timer: divider, seconds counter, sub-week counter, apb registers
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
// Operation
// - seconds counter 28 bits, steps at 1 Hz
// - compare reached raises alarm and wake
// - alarm uses greater than or equal compare
// - sub-week counter 9 bits, minus one per tick
// - sub-week counter one-shot or repeating
// - one to zero raises alarm and wake
// - tick source select decode, bits 3/5/7/9
// - rate select picks divider bit, 0 none
// - divider 15 bits, one step per slow tick
// - divider wrap gives the 1 Hz tick
// - selected divider rate drives sub-second interrupt
// - seconds step on divider zero to one
// - writes finish within two slow ticks
// - reads finish without waiting on slow tick
// - coincident interrupts presented in same cycle
// - hold battery-backed output levels
// - disabled: seconds held, divider cleared
module battery_week_alarm_timer (
  input  wire logic                                   clk,
  input  wire logic                                   rst_b,
  input  wire logic                                   slowTick,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [7:0]                             paddr,
  input  wire logic [31:0]                            pwdata,
  output logic      [31:0]                            prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  output week_timer_pkg::irq_bundle_type              irq,
  output logic                                        wakeEvent,
  output logic      [week_timer_pkg::BATT_W-1:0]      batteryBackedOutput
);

  // control and configuration
  logic                              timerRunEnable_q;
  logic                              wakeEventEnable_q;
  logic [week_timer_pkg::WEEK_W-1:0] weekCount_q;
  logic [week_timer_pkg::WEEK_W-1:0] weekCount_d;
  logic [week_timer_pkg::WEEK_W-1:0] weekCompare_q;
  logic [week_timer_pkg::DIV_W-1:0]  divider_q;
  logic [week_timer_pkg::DIV_W-1:0]  dividerNext;
  logic                              wrapPending_q;
  logic [week_timer_pkg::RATE_W-1:0] subsecondRateSelect_q;
  logic [week_timer_pkg::SRC_W-1:0]  subTickSourceSelect_q;
  logic                              repeatMode_q;
  logic [week_timer_pkg::BATT_W-1:0] battOut_q;
  week_timer_pkg::apb_req_type       req;
  week_timer_pkg::irq_bundle_type    irq_q;
  logic                              wake_q;
  logic                              alarmLevel_q;
  logic [31:0]                       prdata_q;
  logic                              pready_q;
  logic                              pslverr_q;

  // decoded events
  logic                              divStep;
  logic                              secondTick;
  logic                              secondStep;
  logic                              subSecondTick;
  logic [week_timer_pkg::DIV_W-1:0]  rateMask;
  logic                              subTick;
  logic                              subZero;
  logic [week_timer_pkg::SUB_W-1:0]  subCount;
  logic                              alarmLevel;
  logic                              alarmRise;
  logic                              wrEn;
  logic                              rdEn;
  logic                              addrHit;
  logic [31:0]                       readMux;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // apb: a write takes effect at the edge where the registered ready is seen; read data is captured one edge earlier
  assign wrEn = req.psel && req.penable && pready_q && req.pwrite;
  assign rdEn = req.psel && req.penable && !pready_q && !req.pwrite;

  // divider and seconds stepping decode
  assign dividerNext = divider_q + 15'h0001;
  assign divStep     = timerRunEnable_q && slowTick;
  assign secondTick  = divStep && (divider_q == week_timer_pkg::DIV_WRAP);
  assign secondStep  = divStep && (divider_q == 15'h0000) && wrapPending_q;

  // sub-second tick: every 2^(15-n) slow ticks, none for n = 0
  assign rateMask = (15'h0001 << (5'd15 - {1'b0, subsecondRateSelect_q})) - 15'h0001;
  assign subSecondTick = divStep && (subsecondRateSelect_q != 4'h0)
                         && ((dividerNext & rateMask) == 15'h0000);

  // sub-week tick source decode
  always_comb begin
    subTick = 1'b0;
    case (subTickSourceSelect_q)
      week_timer_pkg::SRC_OFF:     subTick = 1'b0;
      week_timer_pkg::SRC_SUBSEC:  subTick = subSecondTick;
      week_timer_pkg::SRC_SECOND:  subTick = secondStep;
      week_timer_pkg::SRC_WEEK_B3: subTick = secondStep && (weekCount_q[2:0] == 3'h7);
      week_timer_pkg::SRC_WEEK_B5: subTick = secondStep && (weekCount_q[4:0] == 5'h1F);
      week_timer_pkg::SRC_WEEK_B7: subTick = secondStep && (weekCount_q[6:0] == 7'h7F);
      week_timer_pkg::SRC_WEEK_B9: subTick = secondStep && (weekCount_q[8:0] == 9'h1FF);
      default:                     subTick = 1'b0;
    endcase
  end

  // next seconds value: a software write wins over the once-per-second step
  always_comb begin
    weekCount_d = weekCount_q;
    if (wrEn && (req.paddr == week_timer_pkg::OFF_WEEK_COUNT)) begin
      weekCount_d = req.pwdata[week_timer_pkg::WEEK_W-1:0];
    end else if (secondStep) begin
      weekCount_d = weekCount_q + 28'h0000001;
    end
  end

  // week alarm level, judged on the next count so that it launches on the
  // same edge as a sub-week alarm raised by the same slow tick
  assign alarmLevel = timerRunEnable_q && (weekCount_d >= weekCompare_q);
  assign alarmRise  = alarmLevel && !alarmLevel_q;

  sub_week_counter subWeek (
    .clk        (clk),
    .rst_b      (rst_b),
    .tick       (subTick),
    .load       (wrEn && (req.paddr == week_timer_pkg::OFF_SUB_COUNT)),
    .loadValue  (req.pwdata[week_timer_pkg::SUB_W-1:0]),
    .repeatMode (repeatMode_q),
    .count      (subCount),
    .zeroEvent  (subZero)
  );

  // control register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timerRunEnable_q  <= week_timer_pkg::RUN_RESET;
      wakeEventEnable_q <= week_timer_pkg::WAKE_RESET;
    end else if (wrEn && (req.paddr == week_timer_pkg::OFF_CONTROL)) begin
      timerRunEnable_q  <= req.pwdata[week_timer_pkg::CTRL_RUN_BIT];
      wakeEventEnable_q <= req.pwdata[week_timer_pkg::CTRL_WAKE_BIT];
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      weekCompare_q         <= week_timer_pkg::COMPARE_RESET;
      subsecondRateSelect_q <= 4'h0;
      subTickSourceSelect_q <= 3'h0;
      repeatMode_q          <= 1'b0;
    end else if (wrEn) begin
      if (req.paddr == week_timer_pkg::OFF_WEEK_COMPARE) begin
        weekCompare_q <= req.pwdata[week_timer_pkg::WEEK_W-1:0];
      end
      if (req.paddr == week_timer_pkg::OFF_RATE_SELECT) begin
        subsecondRateSelect_q <= req.pwdata[week_timer_pkg::RATE_W-1:0];
      end
      if (req.paddr == week_timer_pkg::OFF_SUB_CONTROL) begin
        subTickSourceSelect_q <= req.pwdata[week_timer_pkg::SUBC_SRC_LSB +: 3];
        repeatMode_q          <= req.pwdata[week_timer_pkg::SUBC_REPEAT_BIT];
      end
    end
  end

  // battery-backed output levels, held until software changes them
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      battOut_q <= 6'h00;
    end else if (wrEn && (req.paddr == week_timer_pkg::OFF_BATT_OUTPUT)) begin
      battOut_q <= req.pwdata[week_timer_pkg::BATT_W-1:0];
    end
  end

  // divider: counts slow ticks while running, cleared while stopped
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      divider_q <= 15'h0000;
    end else if (!timerRunEnable_q) begin
      divider_q <= 15'h0000;
    end else if (divStep) begin
      divider_q <= dividerNext;
    end
  end

  // wrap pending: the seconds step waits for the divider to leave zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrapPending_q <= 1'b0;
    end else if (secondTick) begin
      wrapPending_q <= 1'b1;
    end else if (secondStep) begin
      wrapPending_q <= 1'b0;
    end
  end

  // seconds counter: takes its next value on every edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      weekCount_q <= 28'h0000000;
    end else begin
      weekCount_q <= weekCount_d;
    end
  end

  // interrupt lines all launched from one edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_q        <= '0;
      alarmLevel_q <= 1'b0;
    end else begin
      alarmLevel_q       <= alarmLevel;
      irq_q.weekAlarm    <= alarmRise;
      irq_q.subWeekAlarm <= subZero;
      irq_q.oneSecond    <= secondTick;
      irq_q.subSecond    <= subSecondTick;
    end
  end

  // wake output: set by either alarm, reset only by clearing the enable
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_q <= 1'b0;
    end else if (wakeEventEnable_q && (alarmRise || subZero)) begin
      wake_q <= 1'b1;
    end else if (!wakeEventEnable_q) begin
      wake_q <= 1'b0;
    end
  end

  // read mux, no wait on the slow tick
  always_comb begin
    addrHit = 1'b1;
    readMux = 32'h00000000;
    case (req.paddr)
      week_timer_pkg::OFF_CONTROL: begin
        readMux[week_timer_pkg::CTRL_RUN_BIT]  = timerRunEnable_q;
        readMux[week_timer_pkg::CTRL_WAKE_BIT] = wakeEventEnable_q;
      end
      week_timer_pkg::OFF_WEEK_COUNT:   readMux = {4'h0, weekCount_q};
      week_timer_pkg::OFF_WEEK_COMPARE: readMux = {4'h0, weekCompare_q};
      week_timer_pkg::OFF_DIVIDER:      readMux = {17'h00000, divider_q};
      week_timer_pkg::OFF_RATE_SELECT:  readMux = {28'h0000000, subsecondRateSelect_q};
      week_timer_pkg::OFF_SUB_CONTROL:
        readMux = {28'h0000000, repeatMode_q, subTickSourceSelect_q};
      week_timer_pkg::OFF_SUB_COUNT:    readMux = {23'h000000, subCount};
      week_timer_pkg::OFF_BATT_OUTPUT:  readMux = {26'h0000000, battOut_q};
      default:                          addrHit = 1'b0;
    endcase
  end

  // apb answer: one wait state, data and error registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= req.psel && req.penable && !pready_q;
      pslverr_q <= req.psel && req.penable && !pready_q && !addrHit;
      if (rdEn) begin
        prdata_q <= readMux;
      end
    end
  end

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign irq                 = irq_q;
  assign wakeEvent           = wake_q;
  assign batteryBackedOutput = battOut_q;

  secondStep_a: assert property (@(posedge clk) disable iff (!rst_b)
    (secondStep && !(wrEn && req.paddr == week_timer_pkg::OFF_WEEK_COUNT))
    |=> (weekCount_q == $past(weekCount_q) + 28'h0000001) && (divider_q == 15'h0001))
    else $error("seconds step not tied to divider leaving zero");

  divWrap_a: assert property (@(posedge clk) disable iff (!rst_b)
    secondTick |=> (divider_q == 15'h0000) && irq.oneSecond)
    else $error("divider wrap did not raise the one second line");

  divStop_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!timerRunEnable_q && !(wrEn && req.paddr == week_timer_pkg::OFF_WEEK_COUNT))
    |=> (divider_q == 15'h0000) && $stable(weekCount_q))
    else $error("stopped timer changed its counters");

  weekAlarm_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(alarmLevel) |=> irq.weekAlarm ##1 !irq.weekAlarm)
    else $error("week alarm not a single pulse after compare");

  subAlarm_a: assert property (@(posedge clk) disable iff (!rst_b)
    (subTick && subCount == 9'h001 && !(wrEn && req.paddr == week_timer_pkg::OFF_SUB_COUNT))
    |=> irq.subWeekAlarm)
    else $error("sub-week alarm missing on one to zero");

  wakeSet_a: assert property (@(posedge clk) disable iff (!rst_b)
    (wakeEventEnable_q && (alarmRise || subZero)) |=> wakeEvent)
    else $error("wake not raised by alarm");

  wakeHold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (wakeEvent && wakeEventEnable_q) |=> wakeEvent)
    else $error("wake dropped while enabled");

  rateTick_a: assert property (@(posedge clk) disable iff (!rst_b)
    (subsecondRateSelect_q == 4'hF && divStep) |=> irq.subSecond)
    else $error("top rate missed a slow tick");

  syncIrq_a: assert property (@(posedge clk) disable iff (!rst_b)
    (secondTick && subSecondTick) |=> (irq.oneSecond && irq.subSecond))
    else $error("coincident interrupts split");

  apbAnswer_a: assert property (@(posedge clk) disable iff (!rst_b)
    (psel && penable && !pready) |=> pready)
    else $error("apb answer later than one wait state");

  battHold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(wrEn && req.paddr == week_timer_pkg::OFF_BATT_OUTPUT) |=> $stable(batteryBackedOutput))
    else $error("battery-backed output changed without a write");

  wrapCov_c: cover property (@(posedge clk) disable iff (!rst_b) secondTick);
  alarmCov_c: cover property (@(posedge clk) disable iff (!rst_b) irq.weekAlarm && wakeEvent);
  subCov_c: cover property (@(posedge clk) disable iff (!rst_b) subZero && repeatMode_q);
  errCov_c: cover property (@(posedge clk) disable iff (!rst_b) pready && pslverr);

endmodule

/* File: tb/irq_sink_model.sv */
// interrupt aggregator model: counts every pulse on the timer's interrupt lines
`timescale 1ns/1ps
module irq_sink_model (
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire week_timer_pkg::irq_bundle_type irq,
  output logic      [15:0]                    weekCnt,
  output logic      [15:0]                    subWeekCnt,
  output logic      [15:0]                    secCnt,
  output logic      [15:0]                    subSecCnt,
  output logic      [15:0]                    pairCnt
);
  // pulses last one cycle, so each high sample is one event
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      weekCnt    <= 16'h0000;
      subWeekCnt <= 16'h0000;
      secCnt     <= 16'h0000;
      subSecCnt  <= 16'h0000;
      pairCnt    <= 16'h0000;
    end else begin
      weekCnt    <= weekCnt + 16'(irq.weekAlarm);
      subWeekCnt <= subWeekCnt + 16'(irq.subWeekAlarm);
      secCnt     <= secCnt + 16'(irq.oneSecond);
      subSecCnt  <= subSecCnt + 16'(irq.subSecond);
      pairCnt    <= pairCnt + 16'(irq.oneSecond & irq.subSecond)
                    + 16'(irq.weekAlarm & irq.subWeekAlarm);
    end
  end
endmodule

/* File: tb/battery_week_alarm_timer_bench.sv */
// testbench: apb register tests and slow tick sequences for the week alarm timer
`timescale 1ns/1ps
module battery_week_alarm_timer_bench;
  logic                           clk;
  logic                           rst_b;
  logic                           slowTick;
  logic                           psel;
  logic                           penable;
  logic                           pwrite;
  logic [7:0]                     paddr;
  logic [31:0]                    pwdata;
  logic [31:0]                    prdata;
  logic                           pready;
  logic                           pslverr;
  week_timer_pkg::irq_bundle_type irq;
  logic                           wakeEvent;
  logic [5:0]                     battOut;
  logic [15:0]                    weekCnt;
  logic [15:0]                    subWeekCnt;
  logic [15:0]                    secCnt;
  logic [15:0]                    subSecCnt;
  logic [15:0]                    pairCnt;
  logic [31:0]                    rdData;
  logic                           rdErr;
  logic [15:0]                    base;
  int                             num_errors;
  int                             cmp_count;

  battery_week_alarm_timer u_battery_week_alarm_timer (
    .clk(clk), .rst_b(rst_b), .slowTick(slowTick), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .wakeEvent(wakeEvent), .batteryBackedOutput(battOut)
  );

  irq_sink_model u_irq_sink_model (
    .clk(clk), .rst_b(rst_b), .irq(irq), .weekCnt(weekCnt), .subWeekCnt(subWeekCnt),
    .secCnt(secCnt), .subSecCnt(subSecCnt), .pairCnt(pairCnt)
  );

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // one apb transfer; pready, read data and error are taken at the rising edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // let registered outputs and the sink's counters catch up
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    @(negedge clk);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h00000000);
    check(rdData, exp);
  endtask

  // slow ticks: one-cycle pulses two clocks apart
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      slowTick <= 1'b1;
      @(posedge clk);
      slowTick <= 1'b0;
    end
  endtask

  task automatic complete_run;
    $display("errors=%0d comparisons=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog, well past the expected 70k cycles
  initial begin
    #4500000;
    num_errors++;
    complete_run();
  end

  // main sequence
  initial begin
    num_errors = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    slowTick = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rdc(week_timer_pkg::OFF_CONTROL, 32'h00000001);
    rdc(week_timer_pkg::OFF_WEEK_COMPARE, 32'h00FFFFFF);
    rdc(8'h20, 32'h00000000);
    check(32'(rdErr), 32'h00000001);
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    check(32'(rdErr), 32'h00000001);
    apb(1'b1, week_timer_pkg::OFF_CONTROL, 32'hFFFFFFBF);
    rdc(week_timer_pkg::OFF_CONTROL, 32'h00000001);
    apb(1'b1, week_timer_pkg::OFF_WEEK_COMPARE, 32'h00000008);
    // sub-week counter ticks off seconds bit 3; seconds set before the source
    apb(1'b1, week_timer_pkg::OFF_WEEK_COUNT, 32'h00000007);
    apb(1'b1, week_timer_pkg::OFF_SUB_CONTROL, 32'h00000004);
    apb(1'b1, week_timer_pkg::OFF_SUB_COUNT, 32'h00000001);
    apb(1'b1, week_timer_pkg::OFF_RATE_SELECT, 32'h00000001);
    apb(1'b1, week_timer_pkg::OFF_CONTROL, 32'h00000041);
    tick(5);
    rdc(week_timer_pkg::OFF_DIVIDER, 32'h00000005);
    apb(1'b1, week_timer_pkg::OFF_DIVIDER, 32'h00000100);
    rdc(week_timer_pkg::OFF_DIVIDER, 32'h00000005);
    // one full divider period: wrap without a seconds step yet
    tick(32763);
    rdc(week_timer_pkg::OFF_DIVIDER, 32'h00000000);
    rdc(week_timer_pkg::OFF_WEEK_COUNT, 32'h00000007);
    check(32'(secCnt), 32'h00000001);
    check(32'(subSecCnt), 32'h00000002);
    check(32'(pairCnt), 32'h00000001);
    check(32'(weekCnt), 32'h00000000);
    tick(1);
    rdc(week_timer_pkg::OFF_WEEK_COUNT, 32'h00000008);
    rdc(week_timer_pkg::OFF_DIVIDER, 32'h00000001);
    check(32'(weekCnt), 32'h00000001);
    check(32'(wakeEvent), 32'h00000001);
    check(32'(subWeekCnt), 32'h00000001);
    check(32'(pairCnt), 32'h00000002);
    apb(1'b1, week_timer_pkg::OFF_CONTROL, 32'h00000001);
    settle();
    check(32'(wakeEvent), 32'h00000000);
    // counter jumps past the compare value without ever equalling it
    apb(1'b1, week_timer_pkg::OFF_WEEK_COMPARE, 32'h0000000A);
    apb(1'b1, week_timer_pkg::OFF_SUB_COUNT, 32'h00000000);
    apb(1'b1, week_timer_pkg::OFF_WEEK_COUNT, 32'h00000014);
    apb(1'b1, week_timer_pkg::OFF_SUB_COUNT, 32'h00000002);
    settle();
    check(32'(weekCnt), 32'h00000002);
    rdc(week_timer_pkg::OFF_WEEK_COUNT, 32'h00000014);
    // stopped: divider cleared, seconds held
    apb(1'b1, week_timer_pkg::OFF_CONTROL, 32'h00000000);
    tick(3);
    rdc(week_timer_pkg::OFF_DIVIDER, 32'h00000000);
    rdc(week_timer_pkg::OFF_WEEK_COUNT, 32'h00000014);
    apb(1'b1, week_timer_pkg::OFF_CONTROL, 32'h00000001);
    // one-shot sub-week count on the fastest sub-second tick
    apb(1'b1, week_timer_pkg::OFF_RATE_SELECT, 32'h0000000F);
    apb(1'b1, week_timer_pkg::OFF_SUB_CONTROL, 32'h00000001);
    apb(1'b1, week_timer_pkg::OFF_SUB_COUNT, 32'h00000003);
    base = subSecCnt;
    tick(3);
    settle();
    check(32'(subSecCnt - base), 32'h00000003);
    check(32'(subWeekCnt), 32'h00000002);
    rdc(week_timer_pkg::OFF_SUB_COUNT, 32'h00000000);
    tick(2);
    settle();
    check(32'(subWeekCnt), 32'h00000002);
    // repeating mode reloads the start value
    apb(1'b1, week_timer_pkg::OFF_SUB_CONTROL, 32'h00000009);
    apb(1'b1, week_timer_pkg::OFF_SUB_COUNT, 32'h00000002);
    tick(4);
    settle();
    check(32'(subWeekCnt), 32'h00000004);
    rdc(week_timer_pkg::OFF_SUB_COUNT, 32'h00000002);
    // disabled and reserved source codes never decrement
    for (int c = 0; c < 4; c += 3) begin
      apb(1'b1, week_timer_pkg::OFF_SUB_CONTROL, 32'(c));
      apb(1'b1, week_timer_pkg::OFF_SUB_COUNT, 32'h00000005);
      tick(2);
      rdc(week_timer_pkg::OFF_SUB_COUNT, 32'h00000005);
    end
    apb(1'b1, week_timer_pkg::OFF_BATT_OUTPUT, 32'h0000002A);
    settle();
    check(32'(battOut), 32'h0000002A);
    rdc(week_timer_pkg::OFF_BATT_OUTPUT, 32'h0000002A);
    // battery power-on reset mid-run: counters invalid, firmware reinitialises
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rdc(week_timer_pkg::OFF_WEEK_COUNT, 32'h00000000);
    rdc(week_timer_pkg::OFF_WEEK_COMPARE, 32'h00FFFFFF);
    check(32'(battOut), 32'h00000000);
    apb(1'b1, week_timer_pkg::OFF_WEEK_COUNT, 32'h00000014);
    rdc(week_timer_pkg::OFF_WEEK_COUNT, 32'h00000014);
    complete_run();
  end
endmodule
